// ==== led_driver_fault_supervisor.sv ====
// switching supervisor: line range, valley choice, protections, recovery
// assumes comparator inputs come asynchronously from analog circuits
`timescale 1ns/1ps
`default_nettype none
// Operation
// - line above high threshold sets high-line range at once
// - return to low line qualified by 25 ms blanking, falling comparator
// - low line only after continuous 25 ms below; any break restarts it
// - high line turns on at second valley, low line at first
// - gate ends when sensed current exceeds setpoint
// - peak current limit ends gate at once for the cycle
// - sense overvoltage in 4 consecutive cycles stops and recovers
// - 150 percent current trip 4 consecutive cycles stops switching
// - valley pin counts low when below short threshold
// - valley pin low continuously 90 ms flags aux short
// - aux short timer cleared by pin above short threshold or whenever switching is not active
// - after aux short gate stays off 4 s then restarts
// - supply overvoltage stops switching, waits 4 s, resumes
// - compensation node grounded during whole recovery pause
// - compensation grounded under brown-out, lockout or thermal trip
// - switching starts only when line above brown-out on level
// - line below brown-out off level shuts switching down
module led_driver_fault_supervisor #(
  parameter int unsigned LINE_BLANK = supervisor_pkg::LINE_BLANK_CYCLES,
  parameter int unsigned AUX_SHORT = supervisor_pkg::AUX_SHORT_CYCLES,
  parameter int unsigned RECOVERY = supervisor_pkg::RECOVERY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic line_high_cmp,
  input wire logic line_low_cmp,
  input wire logic brownout_on_cmp,
  input wire logic brownout_off_cmp,
  input wire logic valley_cmp,
  input wire logic setpoint_cmp,
  input wire logic peak_current_limit,
  input wire logic sense_pin_overvoltage_trip,
  input wire logic winding_diode_short_trip,
  input wire logic valley_short_cmp,
  input wire logic supply_overvoltage_level,
  input wire logic thermal_trip,
  input wire logic supply_low_lockout,
  output logic gate_drive,
  output logic comp_ground,
  output logic high_line_flag,
  output logic low_line_flag,
  output logic line_undervoltage_detect,
  output logic aux_short_circuit_trip,
  output logic recovering
);
  localparam int unsigned CW = 32;
  logic [1:0] m_high, m_bon, m_boff, m_val, m_sp, m_pk, m_ovp, m_wd, m_vov, m_therm, m_uv;
  logic s_high, s_bon, s_boff, s_val, s_sp, s_pk, s_ovp, s_wd, s_vov, s_therm, s_uv;
  logic low_qual, aux_expired, val_d, turn_on;
  logic [1:0] valley_count, valley_need;
  logic [2:0] ovp_count, wd_count;
  logic ovp_seen, wd_seen;
  logic [CW-1:0] recover_count;
  supervisor_pkg::sup_state_type state;
  logic fault_now, active, valley_edge, cycle_end;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_high <= 2'h0; m_bon <= 2'h0; m_boff <= 2'h0; m_val <= 2'h0;
      m_sp <= 2'h0; m_pk <= 2'h0; m_ovp <= 2'h0; m_wd <= 2'h0;
      m_vov <= 2'h0; m_therm <= 2'h0; m_uv <= 2'h0;
    end else begin
      m_high <= {m_high[0], line_high_cmp};
      m_bon <= {m_bon[0], brownout_on_cmp};
      m_boff <= {m_boff[0], brownout_off_cmp};
      m_val <= {m_val[0], valley_cmp};
      m_sp <= {m_sp[0], setpoint_cmp};
      m_pk <= {m_pk[0], peak_current_limit};
      m_ovp <= {m_ovp[0], sense_pin_overvoltage_trip};
      m_wd <= {m_wd[0], winding_diode_short_trip};
      m_vov <= {m_vov[0], supply_overvoltage_level};
      m_therm <= {m_therm[0], thermal_trip};
      m_uv <= {m_uv[0], supply_low_lockout};
    end
  end
  assign s_high = m_high[1];
  assign s_bon = m_bon[1];
  assign s_boff = m_boff[1];
  assign s_val = m_val[1];
  assign s_sp = m_sp[1];
  assign s_pk = m_pk[1];
  assign s_ovp = m_ovp[1];
  assign s_wd = m_wd[1];
  assign s_vov = m_vov[1];
  assign s_therm = m_therm[1];
  assign s_uv = m_uv[1];

  ////////////////////////////////////////////////////////////////////////////
  // line range
  sync_counter #(.LIMIT(LINE_BLANK), .WIDTH(CW)) u_low_line (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .din(line_low_cmp),
    .count_en(1'b1),
    .dout(),
    .expired(low_qual)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_line_flag <= 1'b0;
      low_line_flag <= 1'b1;
    end else if (s_high) begin
      high_line_flag <= 1'b1;
      low_line_flag <= 1'b0;
    end else if (low_qual) begin
      high_line_flag <= 1'b0;
      low_line_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // brown-out hysteresis
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_undervoltage_detect <= 1'b1;
    end else if (s_boff) begin
      line_undervoltage_detect <= 1'b1;
    end else if (s_bon) begin
      line_undervoltage_detect <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aux short timer: valley_short_cmp high means pin below 0.99 V
  assign active = (state == supervisor_pkg::ST_WAIT_VALLEY) || (state == supervisor_pkg::ST_ON);
  sync_counter #(.LIMIT(AUX_SHORT), .WIDTH(CW)) u_aux_short (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .din(valley_short_cmp),
    .count_en(active),
    .dout(),
    .expired(aux_expired)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_short_circuit_trip <= 1'b0;
    end else if (aux_expired) begin
      aux_short_circuit_trip <= 1'b1;
    end else if (state == supervisor_pkg::ST_OFF) begin
      aux_short_circuit_trip <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // consecutive-cycle fault counters
  assign cycle_end = (state == supervisor_pkg::ST_ON) && (s_sp || s_pk);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovp_seen <= 1'b0;
      wd_seen <= 1'b0;
      ovp_count <= supervisor_pkg::FAULT_COUNT_RESET;
      wd_count <= supervisor_pkg::FAULT_COUNT_RESET;
    end else if (!active) begin
      ovp_seen <= 1'b0;
      wd_seen <= 1'b0;
      ovp_count <= supervisor_pkg::FAULT_COUNT_RESET;
      wd_count <= supervisor_pkg::FAULT_COUNT_RESET;
    end else begin
      if (state == supervisor_pkg::ST_WAIT_VALLEY && s_ovp) begin
        ovp_seen <= 1'b1;
      end
      if (state == supervisor_pkg::ST_ON && s_wd) begin
        wd_seen <= 1'b1;
      end
      // one count per switching cycle, even when a valley is skipped
      if (turn_on) begin
        ovp_seen <= 1'b0;
        ovp_count <= (ovp_seen || s_ovp) ? ovp_count + 3'h1 : 3'h0;
      end
      if (cycle_end) begin
        wd_seen <= 1'b0;
        wd_count <= (wd_seen || s_wd) ? wd_count + 3'h1 : 3'h0;
      end
    end
  end

  assign fault_now = (ovp_count >= 3'(supervisor_pkg::FAULT_CYCLES))
    || (wd_count >= 3'(supervisor_pkg::FAULT_CYCLES))
    || aux_expired || s_vov;

  ////////////////////////////////////////////////////////////////////////////
  // switching sequencer
  assign valley_edge = s_val && !val_d;
  assign valley_need = high_line_flag ? supervisor_pkg::VALLEY_HIGH_LINE
    : supervisor_pkg::VALLEY_LOW_LINE;
  assign turn_on = (state == supervisor_pkg::ST_WAIT_VALLEY) && valley_edge
    && (valley_count + 2'h1 >= valley_need);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= supervisor_pkg::ST_OFF;
      val_d <= 1'b0;
      valley_count <= supervisor_pkg::VALLEY_COUNT_RESET;
      recover_count <= '0;
      gate_drive <= 1'b0;
    end else begin
      val_d <= s_val;
      case (state)
        supervisor_pkg::ST_OFF: begin
          gate_drive <= 1'b0;
          valley_count <= supervisor_pkg::VALLEY_COUNT_RESET;
          if (!line_undervoltage_detect && !s_uv && !s_therm && !s_vov) begin
            state <= supervisor_pkg::ST_WAIT_VALLEY;
          end
        end
        supervisor_pkg::ST_WAIT_VALLEY: begin
          if (fault_now) begin
            state <= supervisor_pkg::ST_RECOVER;
            recover_count <= '0;
          end else if (line_undervoltage_detect || s_uv || s_therm) begin
            state <= supervisor_pkg::ST_OFF;
          end else if (valley_edge) begin
            if (turn_on) begin
              state <= supervisor_pkg::ST_ON;
              gate_drive <= 1'b1;
              valley_count <= supervisor_pkg::VALLEY_COUNT_RESET;
            end else begin
              valley_count <= valley_count + 2'h1;
            end
          end
        end
        supervisor_pkg::ST_ON: begin
          if (fault_now) begin
            state <= supervisor_pkg::ST_RECOVER;
            recover_count <= '0;
            gate_drive <= 1'b0;
          end else if (s_pk || s_sp || line_undervoltage_detect || s_uv || s_therm) begin
            state <= supervisor_pkg::ST_WAIT_VALLEY;
            gate_drive <= 1'b0;
          end
        end
        supervisor_pkg::ST_RECOVER: begin
          gate_drive <= 1'b0;
          if (recover_count >= CW'(RECOVERY - 1)) begin
            state <= supervisor_pkg::ST_OFF;
          end else begin
            recover_count <= recover_count + CW'(1);
          end
        end
        default: begin
          state <= supervisor_pkg::ST_OFF;
          gate_drive <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compensation node clamp and status
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_ground <= 1'b1;
      recovering <= 1'b0;
    end else begin
      comp_ground <= (state == supervisor_pkg::ST_RECOVER) || fault_now
        || line_undervoltage_detect || s_uv || s_therm;
      recovering <= (state == supervisor_pkg::ST_RECOVER);
    end
  end
endmodule // led_driver_fault_supervisor
`default_nettype wire

// ==== led_driver_fault_supervisor_properties.sv ====
// port assertions for the fault supervisor
// assumes one 100 MHz sys_clk domain and rst_b active low
`timescale 1ns/1ps
`default_nettype none
module led_driver_fault_supervisor_properties #(
  parameter int unsigned LINE_BLANK = 20,
  parameter int unsigned AUX_SHORT = 50,
  parameter int unsigned RECOVERY = 100
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic line_high_cmp,
  input wire logic line_low_cmp,
  input wire logic brownout_off_cmp,
  input wire logic setpoint_cmp,
  input wire logic peak_current_limit,
  input wire logic valley_short_cmp,
  input wire logic supply_low_lockout,
  input wire logic gate_drive,
  input wire logic comp_ground,
  input wire logic high_line_flag,
  input wire logic low_line_flag,
  input wire logic line_undervoltage_detect,
  input wire logic aux_short_circuit_trip,
  input wire logic recovering
);
  int unsigned low_run, short_run, rec_run;
  // run lengths of the levels that the timers qualify
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run <= '0;
      short_run <= '0;
      rec_run <= '0;
    end else begin
      low_run <= line_low_cmp ? low_run + 32'h1 : '0;
      short_run <= valley_short_cmp ? short_run + 32'h1 : '0;
      rec_run <= recovering ? rec_run + 32'h1 : '0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_high; line_high_cmp [*5] |-> high_line_flag; endproperty
  a_high: assert property (p_high) else $error("high line range missed");
  property p_low; $rose(low_line_flag) |-> low_run >= LINE_BLANK; endproperty
  a_low: assert property (p_low) else $error("low line range too early");
  property p_setpoint; gate_drive && setpoint_cmp |-> ##[1:4] !gate_drive; endproperty
  a_setpoint: assert property (p_setpoint) else $error("gate not ended by setpoint");
  property p_peak; gate_drive && peak_current_limit |-> ##[1:4] !gate_drive; endproperty
  a_peak: assert property (p_peak) else $error("gate not ended by peak limit");
  property p_aux; $rose(aux_short_circuit_trip) |-> short_run >= AUX_SHORT; endproperty
  a_aux: assert property (p_aux) else $error("aux short flagged too early");
  property p_rec_len;
    $fell(recovering) |-> rec_run + 32'h2 >= RECOVERY && rec_run <= RECOVERY + 32'h2;
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery pause length wrong");
  property p_rec_off; recovering |-> comp_ground && !gate_drive; endproperty
  a_rec_off: assert property (p_rec_off) else $error("pause not quiet");
  property p_lockout; supply_low_lockout [*6] |-> comp_ground && !gate_drive; endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not obeyed");
  property p_brownout;
    brownout_off_cmp [*6] |-> line_undervoltage_detect && !gate_drive;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out not obeyed");
endmodule // led_driver_fault_supervisor_properties
bind led_driver_fault_supervisor led_driver_fault_supervisor_properties #(
  .LINE_BLANK(LINE_BLANK), .AUX_SHORT(AUX_SHORT), .RECOVERY(RECOVERY)
) i_props (.sys_clk, .rst_b, .line_high_cmp, .line_low_cmp, .brownout_off_cmp, .setpoint_cmp,
  .peak_current_limit, .valley_short_cmp, .supply_low_lockout, .gate_drive, .comp_ground,
  .high_line_flag, .low_line_flag, .line_undervoltage_detect, .aux_short_circuit_trip,
  .recovering);
`default_nettype wire

// ==== led_driver_fault_supervisor_tb.sv ====
// self-checking bench for the fault supervisor
// assumes the partner model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module led_driver_fault_supervisor_tb;
  localparam int unsigned BLANK = 20;
  logic sys_clk = 1'h0, rst_b = 1'h0, line_high_cmp = 1'h0, line_low_cmp = 1'h1;
  logic brownout_on_cmp = 1'h0, brownout_off_cmp = 1'h1, peak_current_limit = 1'h0;
  logic thermal_trip = 1'h0;
  logic supply_low_lockout = 1'h0, armed = 1'h0, cur_hi = 1'h0, hi_line, gate_q = 1'h0;
  logic valley_q;
  logic [3:0] flt = 4'h0;
  logic [1:0] vcnt = 2'h0;
  logic [7:0] on_len = 8'h4, gap = 8'hA;
  logic gate_drive, comp_ground, high_line_flag, low_line_flag, line_undervoltage_detect;
  logic aux_short_circuit_trip, recovering, valley_cmp, setpoint_cmp;
  int num_errors = 0, n_tests = 0, n_rise = 0, rise_mark = 0;
  initial forever #5 sys_clk = !sys_clk;
  led_driver_fault_supervisor #(.LINE_BLANK(BLANK), .AUX_SHORT(50), .RECOVERY(100)) i_dut (
    .sys_clk, .rst_b, .line_high_cmp, .line_low_cmp, .brownout_on_cmp, .brownout_off_cmp,
    .valley_cmp,
    .setpoint_cmp, .peak_current_limit, .sense_pin_overvoltage_trip(flt[0]),
    .winding_diode_short_trip(flt[1]), .valley_short_cmp(flt[3]),
    .supply_overvoltage_level(flt[2]), .thermal_trip, .supply_low_lockout, .gate_drive,
    .comp_ground, .high_line_flag, .low_line_flag, .line_undervoltage_detect,
    .aux_short_circuit_trip, .recovering);
  led_gate_partner i_partner (.sys_clk, .gate_drive, .on_len, .gap, .valley_cmp, .setpoint_cmp);
  function automatic logic [1:0] exp_valleys(logic h);
    return h ? supervisor_pkg::VALLEY_HIGH_LINE : supervisor_pkg::VALLEY_LOW_LINE;
  endfunction
  task automatic check(logic [1:0] seen, logic [1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic await_rise(int n);
    int s = n_rise;
    int i = 0;
    while (n_rise < s + n && i < 2000) begin
      tick();
      i++;
    end
    check(n_rise >= s + n, 1'h1);
  endtask
  task automatic wait_rec(logic v, int lim);
    int i = 0;
    while (recovering !== v && i < lim) begin
      tick();
      i++;
    end
    check(recovering, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // valleys seen while off, compared at each turn-on while armed is set
  always @(posedge sys_clk) begin
    if (gate_drive && !gate_q) begin
      n_rise++;
      if (armed) check(vcnt, exp_valleys(cur_hi));
    end
    if (gate_drive) vcnt = 2'h0;
    else if (valley_cmp && !valley_q) vcnt++;
    gate_q = gate_drive;
    valley_q = valley_cmp;
  end
  initial begin
    #(20000 * 10);
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(98));
    tick(15);
    check({gate_drive, comp_ground}, 2'h1);
    check({low_line_flag, line_undervoltage_detect}, 2'h3);
    tick();
    rst_b = 1'h1;
    tick(6);
    check(gate_drive, 1'h0);
    brownout_on_cmp = 1'h1;
    brownout_off_cmp = 1'h0;
    tick(6);
    check({line_undervoltage_detect, comp_ground}, 2'h0);
    $display("done: reset and start");
    for (int i = 0; i < 5; i++) begin
      armed = 1'h0;
      on_len = 8'h3 + 8'($urandom % 6);
      gap = 8'h8 + 8'($urandom % 8);
      hi_line = (i < 2) ? !i[0] : 1'($urandom % 2);
      line_high_cmp = hi_line;
      line_low_cmp = !hi_line;
      if (!hi_line) begin
        tick(BLANK - 4);
        line_low_cmp = 1'h0;
        tick();
        line_low_cmp = 1'h1;
        tick(6);
        check(high_line_flag, cur_hi);
        tick(BLANK + 6);
      end else tick(6);
      cur_hi = hi_line;
      check({high_line_flag, low_line_flag}, {hi_line, !hi_line});
      await_rise(2);
      armed = 1'h1;
      await_rise(3);
      $display("done: line range %0d", hi_line);
    end
    armed = 1'h0;
    // high line from here on: two valleys per cycle must still count once
    line_high_cmp = 1'h1;
    line_low_cmp = 1'h0;
    on_len = 8'hFF;
    peak_current_limit = 1'h1;
    await_rise(2);
    tick(4);
    check(gate_drive, 1'h0);
    peak_current_limit = 1'h0;
    on_len = 8'h5;
    for (int k = 0; k < 4; k++) begin
      rise_mark = n_rise;
      flt = 4'h1 << k;
      wait_rec(1'h1, 800);
      if (k < 2) check((n_rise - rise_mark) >= (k == 0 ? 4 : 3), 1'h1);
      check({comp_ground, gate_drive}, 2'h2);
      check(aux_short_circuit_trip, k == 3);
      flt = 4'h0;
      wait_rec(1'h0, 130);
      await_rise(1);
      $display("done: fault %0d", k);
    end
    for (int j = 0; j < 2; j++) begin
      {thermal_trip, supply_low_lockout} = 2'h1 << j;
      tick(8);
      check({comp_ground, gate_drive}, 2'h2);
      {thermal_trip, supply_low_lockout} = 2'h0;
      await_rise(1);
    end
    brownout_on_cmp = 1'h0;
    brownout_off_cmp = 1'h1;
    tick(8);
    check({line_undervoltage_detect, comp_ground}, 2'h3);
    check(gate_drive, 1'h0);
    rst_b = 1'h0;
    tick();
    check({gate_drive, recovering}, 2'h0);
    rst_b = 1'h1;
    tick(2);
    $display("done: brown-out and reset");
    results();
  end
endmodule // led_driver_fault_supervisor_tb
`default_nettype wire

// ==== led_gate_partner.sv ====
// far side model: valley ringing and current sense comparators
// assumes gate_drive from the supervisor; outputs move 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module led_gate_partner (
  input wire logic sys_clk,
  input wire logic gate_drive,
  input wire logic [7:0] on_len,
  input wire logic [7:0] gap,
  output logic valley_cmp,
  output logic setpoint_cmp
);
  int cnt = 0;
  logic last = 1'h0;
  initial valley_cmp = 1'h0;
  initial setpoint_cmp = 1'h0;
  // valleys ring only while the switch is off, from 4 cycles after turn-off, 3 cycles wide every gap cycles
  always @(posedge sys_clk) begin
    #1;
    cnt = (gate_drive == last) ? cnt + 1 : 0;
    last = gate_drive;
    setpoint_cmp = gate_drive && cnt >= on_len;
    valley_cmp = !gate_drive && cnt >= 4 && (cnt - 4) % gap < 3;
  end
endmodule // led_gate_partner
`default_nettype wire

// ==== supervisor_pkg.sv ====
// constants for the led driver fault supervisor
// assumes a 100 MHz system clock
`default_nettype none
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned LINE_BLANK_MS = 25;
  localparam int unsigned AUX_SHORT_MS = 90;
  localparam int unsigned RECOVERY_S = 4;
  localparam int unsigned LINE_BLANK_CYCLES = (CLK_HZ / 1000) * LINE_BLANK_MS;
  localparam int unsigned AUX_SHORT_CYCLES = (CLK_HZ / 1000) * AUX_SHORT_MS;
  localparam int unsigned RECOVERY_CYCLES = CLK_HZ * RECOVERY_S;
  localparam int unsigned FAULT_CYCLES = 4;
  localparam logic [2:0] FAULT_COUNT_RESET = 3'h0;
  localparam logic [1:0] VALLEY_LOW_LINE = 2'h1;
  localparam logic [1:0] VALLEY_HIGH_LINE = 2'h2;
  localparam logic [1:0] VALLEY_COUNT_RESET = 2'h0;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT_VALLEY = 2'b01,
    ST_ON = 2'b10,
    ST_RECOVER = 2'b11
  } sup_state_type;
endpackage
`default_nettype wire

// ==== sync_counter.sv ====
// two-flop synchroniser followed by a run-length counter
// assumes din is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sync_counter #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic din,
  input wire logic count_en,
  output logic dout,
  output logic expired
);
  logic meta;
  logic [WIDTH-1:0] count;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

  // counts while the synchronised level stays high and count_en is set, restarts on any drop of either
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      expired <= 1'b0;
    end else if (!dout || !count_en) begin
      count <= '0;
      expired <= 1'b0;
    end else if (count >= WIDTH'(LIMIT - 1)) begin
      expired <= 1'b1;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule // sync_counter
`default_nettype wire
